// File: verilog/iar_defs.svh
`ifndef IAR_DEFS_SVH
`define IAR_DEFS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define IAR_ADDR_ONE        32'hE000_ED64
`define IAR_ADDR_ONE_NS     32'hE002_ED64
`define IAR_ADDR_TWO        32'hE000_ED68
`define IAR_ADDR_TWO_NS     32'hE002_ED68
`define IAR_ADDR_THREE      32'h0000_ED6C
`define IAR_ADDR_THREE_NS   32'h0002_ED6C

// ****************************************************************
// field positions (low bit of each nibble)
// ****************************************************************
`define IAR_LSB_N7          28
`define IAR_LSB_N6          24
`define IAR_LSB_N5          20
`define IAR_LSB_N4          16
`define IAR_LSB_N3          12
`define IAR_LSB_N2          8
`define IAR_LSB_N1          4
`define IAR_LSB_N0          0

// ****************************************************************
// field values
// ****************************************************************
`define IAR_ONE_SWITCH      4'h2
`define IAR_ONE_WIDE        4'h2
`define IAR_ONE_COND        4'h1
`define IAR_ONE_EXT_BASIC   4'h1
`define IAR_ONE_EXT_PACKED  4'h2
`define IAR_TWO_REVERSE     4'h2
`define IAR_TWO_ULM_BASIC   4'h1
`define IAR_TWO_ULM_DSP     4'h2
`define IAR_TWO_SLM_BASIC   4'h1
`define IAR_TWO_SLM_DSP     4'h3
`define IAR_TWO_XMUL        4'h2
`define IAR_TWO_HINT        4'h3
`define IAR_TWO_ACQREL      4'h2
`define IAR_THREE_ONE       4'h1
`define IAR_THREE_PACK_BAS  4'h1
`define IAR_THREE_PACK_DSP  4'h3
`define IAR_THREE_SAT_BAS   4'h0
`define IAR_THREE_SAT_DSP   4'h1
`define IAR_RES_ZERO        4'h0
`define IAR_MULTI_DEFAULT   4'h0

`endif

// File: verilog/iar_pkg.sv
`default_nettype none
package iar_pkg;

    // ****************************************************************
    // register selection from the address decoder
    // ****************************************************************
    typedef enum logic [1:0] {
        IAR_SEL_NONE  = 2'b00,
        IAR_SEL_ONE   = 2'b01,
        IAR_SEL_TWO   = 2'b10,
        IAR_SEL_THREE = 2'b11
    } iar_sel_t;

    // one access request from the system address map
    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        priv;
        logic        nonSecure;
        logic        debug;
    } iar_req_t;

    // answer to one access
    typedef struct packed {
        logic [31:0] rdata;
        logic        fault;
        logic        hit;
    } iar_rsp_t;

endpackage
`default_nettype wire

// File: verilog/iar_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "iar_defs.svh"
module iar_addr_decode (
    input  wire logic [31:0]      addr,
    output iar_pkg::iar_sel_t     sel,
    output logic                  aliasHit
);
    import iar_pkg::*;

    // ****************************************************************
    // exact word decode, secure and alias views
    // ****************************************************************
    always_comb begin
        sel      = IAR_SEL_NONE;
        aliasHit = 1'b0;
        unique case (addr)
            `IAR_ADDR_ONE: begin
                sel = IAR_SEL_ONE;
            end
            `IAR_ADDR_ONE_NS: begin
                sel      = IAR_SEL_ONE;
                aliasHit = 1'b1;
            end
            `IAR_ADDR_TWO: begin
                sel = IAR_SEL_TWO;
            end
            `IAR_ADDR_TWO_NS: begin
                sel      = IAR_SEL_TWO;
                aliasHit = 1'b1;
            end
            `IAR_ADDR_THREE: begin
                sel = IAR_SEL_THREE;
            end
            `IAR_ADDR_THREE_NS: begin
                sel      = IAR_SEL_THREE;
                aliasHit = 1'b1;
            end
            default: begin
                sel      = IAR_SEL_NONE;
                aliasHit = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// File: verilog/iar_attr_values.sv
`timescale 1ns/1ps
`default_nettype none
`include "iar_defs.svh"
module iar_attr_values #(
    parameter bit       DSP_OPT     = 1'b0,
    parameter bit       EXTEND_WIDE = 1'b0,
    parameter bit [3:0] MULTI_INT   = `IAR_MULTI_DEFAULT
) (
    output logic [31:0] attrOne,
    output logic [31:0] attrTwo,
    output logic [31:0] attrThree
);

    // ****************************************************************
    // elaboration-time field choices
    // ****************************************************************
    localparam logic [3:0] EXT_V = (DSP_OPT && EXTEND_WIDE) ?
        `IAR_ONE_EXT_PACKED : `IAR_ONE_EXT_BASIC;
    localparam logic [3:0] ULM_V = DSP_OPT ?
        `IAR_TWO_ULM_DSP : `IAR_TWO_ULM_BASIC;
    localparam logic [3:0] SLM_V = DSP_OPT ?
        `IAR_TWO_SLM_DSP : `IAR_TWO_SLM_BASIC;
    localparam logic [3:0] PACK_V = DSP_OPT ?
        `IAR_THREE_PACK_DSP : `IAR_THREE_PACK_BAS;
    localparam logic [3:0] SAT_V = DSP_OPT ?
        `IAR_THREE_SAT_DSP : `IAR_THREE_SAT_BAS;

    // first register: upper nibble and low 12 bits reserved zero
    assign attrOne = {`IAR_RES_ZERO,
                      `IAR_ONE_SWITCH,
                      `IAR_ONE_WIDE,
                      `IAR_ONE_COND,
                      EXT_V,
                      {3{`IAR_RES_ZERO}}};

    // second register: 27:24 reserved zero
    assign attrTwo = {`IAR_TWO_REVERSE,
                      `IAR_RES_ZERO,
                      ULM_V,
                      SLM_V,
                      `IAR_TWO_XMUL,
                      MULTI_INT,
                      `IAR_TWO_HINT,
                      `IAR_TWO_ACQREL};

    // third register: 31:28 reserved zero
    assign attrThree = {`IAR_RES_ZERO,
                        {5{`IAR_THREE_ONE}},
                        PACK_V,
                        SAT_V};

endmodule
`default_nettype wire

// File: verilog/iar_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "iar_defs.svh"
module iar_id_regs #(
    parameter bit       MAINLINE_OPT = 1'b1,
    parameter bit       DSP_OPT      = 1'b0,
    parameter bit       EXTEND_WIDE  = 1'b0,
    parameter bit [3:0] MULTI_INT    = `IAR_MULTI_DEFAULT
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              regValid,
    input  wire iar_pkg::iar_req_t regReq,
    output logic                   regAck,
    output iar_pkg::iar_rsp_t      regRsp
);
    import iar_pkg::*;

    // ****************************************************************
    // constant register contents
    // ****************************************************************
    logic [31:0] attrOne;
    logic [31:0] attrTwo;
    logic [31:0] attrThree;
    iar_sel_t    sel;
    logic        aliasHit;
    logic [31:0] word;
    logic        unpriv;
    logic        aliasBlocked;
    logic        readOk;
    iar_rsp_t    rsp_d;
    iar_rsp_t    rsp_q;
    logic        ack_q;

    // values fixed when the design is built
    iar_attr_values #(
        .DSP_OPT     (DSP_OPT),
        .EXTEND_WIDE (EXTEND_WIDE),
        .MULTI_INT   (MULTI_INT)
    ) uValues (
        .attrOne     (attrOne),
        .attrTwo     (attrTwo),
        .attrThree   (attrThree)
    );

    // ****************************************************************
    // address decode
    // ****************************************************************
    iar_addr_decode uDecode (
        .addr     (regReq.addr),
        .sel      (sel),
        .aliasHit (aliasHit)
    );

    // one shared copy serves both views
    always_comb begin
        unique case (sel)
            IAR_SEL_ONE:   word = attrOne;
            IAR_SEL_TWO:   word = attrTwo;
            IAR_SEL_THREE: word = attrThree;
            IAR_SEL_NONE:  word = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // access checks
    // ****************************************************************
    // debugger counts as privileged; plain user code does not
    assign unpriv       = !regReq.priv && !regReq.debug;
    // alias view only for secure privileged software
    assign aliasBlocked = aliasHit &&
                          (regReq.nonSecure || regReq.debug);
    assign readOk       = MAINLINE_OPT && !regReq.write &&
                          !unpriv && !aliasBlocked;

    // answer word, fault and hit for this access
    always_comb begin
        rsp_d.hit   = (sel != IAR_SEL_NONE);
        rsp_d.fault = rsp_d.hit && unpriv;
        // writes store nothing and read back zero
        rsp_d.rdata = (rsp_d.hit && readOk) ?
                      word : 32'h0000_0000;
    end

    // ****************************************************************
    // registered answer, one cycle after the request
    // ****************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= regValid;
        end
    end

    // answer data held until the next request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_q <= '0;
        end else if (regValid) begin
            rsp_q <= rsp_d;
        end
    end

    assign regAck = ack_q;
    assign regRsp = rsp_q;

endmodule
`default_nettype wire

// File: dv/iar_id_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "iar_defs.svh"
module iar_id_regs_sva #(
    parameter bit       MAINLINE_OPT = 1'b1,
    parameter bit       DSP_OPT      = 1'b0,
    parameter bit       EXTEND_WIDE  = 1'b0,
    parameter bit [3:0] MULTI_INT    = `IAR_MULTI_DEFAULT
) (
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic              regValid,
    input wire iar_pkg::iar_req_t regReq,
    input wire logic              regAck,
    input wire iar_pkg::iar_rsp_t regRsp
);
    import iar_pkg::*;
    // ********
    // access checks, per build options
    // ********

    // whole register values for this build
    localparam logic [31:0] ONE_V = !MAINLINE_OPT ? 32'h0000_0000 :
        (DSP_OPT && EXTEND_WIDE) ? 32'h0221_2000 : 32'h0221_1000;
    localparam logic [31:0] TWO_V = !MAINLINE_OPT ? 32'h0000_0000 :
        (DSP_OPT ? 32'h2023_2032 : 32'h2011_2032) |
        {20'h0_0000, MULTI_INT, 8'h00};
    localparam logic [31:0] THREE_V = !MAINLINE_OPT ? 32'h0000_0000 :
        DSP_OPT ? 32'h0111_1131 : 32'h0111_1110;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // address is one of the six decoded words
    function automatic logic mapped(logic [31:0] a);
        return (a & 32'hFFFD_FFFF) inside
            {`IAR_ADDR_ONE, `IAR_ADDR_TWO, `IAR_ADDR_THREE};
    endfunction

    // privileged secure read of one address
    sequence rd_s(a);
        regValid && !regReq.write && regReq.priv && !regReq.nonSecure
            && !regReq.debug && regReq.addr == a;
    endsequence

    ack_next_a: assert property (regValid |=> regAck)
        else $error("no answer one cycle after request");
    ack_cause_a: assert property (regAck |-> $past(regValid))
        else $error("answer without request");
    rsp_hold_a: assert property (!regValid |=> $stable(regRsp))
        else $error("response changed while idle");
    one_value_a: assert property (rd_s(`IAR_ADDR_ONE) |=>
        regRsp.rdata == ONE_V && regRsp.hit)
        else $error("first register value wrong");
    two_value_a: assert property (rd_s(`IAR_ADDR_TWO) |=>
        regRsp.rdata == TWO_V)
        else $error("second register value wrong");
    three_value_a: assert property (rd_s(`IAR_ADDR_THREE) |=>
        regRsp.rdata == THREE_V)
        else $error("third register value wrong");
    shared_copy_a: assert property (rd_s(`IAR_ADDR_TWO_NS) |=>
        regRsp.rdata == TWO_V)
        else $error("alias view differs from register");
    alias_zero_a: assert property (regValid && regReq.priv
        && regReq.nonSecure && regReq.addr[17] && mapped(regReq.addr)
        |=> regRsp.rdata == '0 && !regRsp.fault)
        else $error("alias not zero for non-secure");
    unpriv_fault_a: assert property (regValid && !regReq.priv
        && !regReq.debug && mapped(regReq.addr)
        |=> regRsp.fault && regRsp.rdata == '0)
        else $error("unprivileged access did not fault");
    write_none_a: assert property (regValid && regReq.write
        |=> regRsp.rdata == '0)
        else $error("write returned data");
    unmapped_a: assert property (regValid && !mapped(regReq.addr)
        |=> !regRsp.hit && !regRsp.fault && regRsp.rdata == '0)
        else $error("unmapped address answered");
endmodule
bind iar_id_regs iar_id_regs_sva #(
    .MAINLINE_OPT (MAINLINE_OPT),
    .DSP_OPT      (DSP_OPT),
    .EXTEND_WIDE  (EXTEND_WIDE),
    .MULTI_INT    (MULTI_INT)
) i_sva (.mclk(mclk), .reset_n(reset_n),
    .regValid(regValid), .regReq(regReq), .regAck(regAck), .regRsp(regRsp));
`default_nettype wire

// File: dv/iar_id_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "iar_defs.svh"
module iar_id_regs_tb;
    import iar_pkg::*;
    logic     mclk = 1'b0;
    logic     reset_n;
    logic     regValid;
    iar_req_t regReq = '0;
    logic     regAck;
    iar_rsp_t regRsp;
    logic     ackDsp;
    iar_rsp_t rspDsp;
    logic     ackBare;
    iar_rsp_t rspBare;
    int       failures = 0;
    int       nCompared = 0;

    iar_id_regs i_dut (.mclk(mclk), .reset_n(reset_n), .regValid(regValid),
        .regReq(regReq), .regAck(regAck), .regRsp(regRsp));

    // option-rich build, and a build without the mainline option
    iar_id_regs #(.MAINLINE_OPT(1'b1), .DSP_OPT(1'b1), .EXTEND_WIDE(1'b1),
        .MULTI_INT(4'h2)) i_dut_dsp (.mclk(mclk), .reset_n(reset_n),
        .regValid(regValid), .regReq(regReq), .regAck(ackDsp),
        .regRsp(rspDsp));
    iar_id_regs #(.MAINLINE_OPT(1'b0), .DSP_OPT(1'b0), .EXTEND_WIDE(1'b1),
        .MULTI_INT(4'h1)) i_dut_bare (.mclk(mclk), .reset_n(reset_n),
        .regValid(regValid), .regReq(regReq), .regAck(ackBare),
        .regRsp(rspBare));

    // ********
    // clock and helpers
    // ********
    always #2 mclk = ~mclk;

    // expected answer for one request in one build
    function automatic iar_rsp_t exp_f(iar_req_t r, bit mainOn, bit dsp,
                                       bit ext, logic [3:0] multi);
        iar_rsp_t e;
        e = '0;
        case (r.addr & 32'hFFFD_FFFF)
            `IAR_ADDR_ONE: begin
                e.rdata = 32'h0221_1000;
                if (dsp && ext) e.rdata = 32'h0221_2000;
            end
            `IAR_ADDR_TWO: begin
                e.rdata = dsp ? 32'h2023_2032 : 32'h2011_2032;
                e.rdata[11:8] = multi;
            end
            `IAR_ADDR_THREE: begin
                e.rdata = dsp ? 32'h0111_1131 : 32'h0111_1110;
            end
            default: return e;
        endcase
        e.hit = 1'b1;
        e.fault = !r.priv && !r.debug;
        if (!mainOn || e.fault || r.write ||
            (r.addr[17] && (r.nonSecure || r.debug))) begin
            e.rdata = '0;
        end
        return e;
    endfunction

    // one answer against its expectation
    task automatic chk(logic ack, iar_rsp_t got, iar_rsp_t exp);
        nCompared++;
        if (ack !== 1'b1 || got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one word access, flags are write, priv, nonSecure, debug
    task automatic acc(logic [31:0] a, logic [3:0] f);
        iar_req_t r;
        r = iar_req_t'({a, f});
        regValid = 1'b1;
        regReq = r;
        @(posedge mclk);
        #1;
        chk(regAck, regRsp, exp_f(r, 1'b1, 1'b0, 1'b0, 4'h0));
        chk(ackDsp, rspDsp, exp_f(r, 1'b1, 1'b1, 1'b1, 4'h2));
        chk(ackBare, rspBare, exp_f(r, 1'b0, 1'b0, 1'b1, 4'h1));
    endtask

    // idle cycles, answer must hold
    task automatic idle(int n);
        iar_rsp_t held;
        iar_rsp_t heldDsp;
        iar_rsp_t heldBare;
        regValid = 1'b0;
        held = regRsp;
        heldDsp = rspDsp;
        heldBare = rspBare;
        repeat (n) @(posedge mclk);
        #1;
        nCompared++;
        if (regAck !== 1'b0 || regRsp !== held ||
            ackDsp !== 1'b0 || rspDsp !== heldDsp ||
            ackBare !== 1'b0 || rspBare !== heldBare) begin
            failures++;
            $display("mismatch at %0t: response not held", $time);
        end
    endtask

    task automatic do_reset();
        regValid = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        nCompared++;
        if (regAck !== 1'b0 || regRsp !== '0 ||
            ackDsp !== 1'b0 || rspDsp !== '0 ||
            ackBare !== 1'b0 || rspBare !== '0) begin
            failures++;
            $display("mismatch at %0t: reset state", $time);
        end
        reset_n = 1'b1;
    endtask

    task automatic give_verdict();
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        logic [31:0] tbl [6];
        logic [31:0] a;
        tbl = '{`IAR_ADDR_ONE, `IAR_ADDR_TWO, `IAR_ADDR_THREE,
            `IAR_ADDR_ONE_NS, `IAR_ADDR_TWO_NS, `IAR_ADDR_THREE_NS};
        void'($urandom(32'h8108BDBC));
        do_reset();
        acc(`IAR_ADDR_ONE, 4'b0100);
        acc(`IAR_ADDR_TWO, 4'b0100);
        acc(`IAR_ADDR_THREE, 4'b0100);
        acc(`IAR_ADDR_TWO_NS, 4'b0100);
        acc(`IAR_ADDR_THREE_NS, 4'b0110);
        acc(`IAR_ADDR_TWO_NS, 4'b0001);
        acc(`IAR_ADDR_ONE, 4'b0000);
        acc(`IAR_ADDR_TWO, 4'b1100);
        acc(`IAR_ADDR_TWO, 4'b0100);
        acc(32'hE000_ED6C, 4'b0100);
        idle(3);
        repeat (300) begin
            a = ($urandom % 4 == 0) ? $urandom : tbl[$urandom % 6];
            acc(a, 4'($urandom));
            if ($urandom % 5 == 0) idle(1 + $urandom % 3);
        end
        do_reset();
        acc(`IAR_ADDR_THREE, 4'b0101);
        idle(1);
        give_verdict();
    end

    // watchdog against a hang
    initial begin
        #20000;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
